// >>> core/hsa_pkg.sv
// Constants and types shared by the hardware-monitor alarm register block
package hsa_pkg;
   // Clock and time base
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_TIME_US = 1000;
   localparam int TICK_CYCLES = TICK_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int WARN_TIME_MIN = 3;
   localparam int WARN_TICKS = WARN_TIME_MIN * 60 * 1000 / TICK_TIME_US;
   // Bus
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   // Banks
   localparam logic [3:0] BANK_CTRL = 4'h0;
   localparam logic [3:0] BANK_AUX = 4'h2;
   localparam logic [3:0] BANK_ALM = 4'h4;
   localparam logic [3:0] BANK_VRAM = 4'h5;
   // Indexes
   localparam logic [7:0] IDX_MON_CTRL = 8'h5d;
   localparam logic [7:0] IDX_AUX_LIM_HI = 8'h55;
   localparam logic [7:0] IDX_AUX_LIM_LO = 8'h56;
   localparam logic [7:0] IDX_IRQ_STAT = 8'h50;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h51;
   localparam logic [7:0] IDX_ALM_CTL = 8'h53;
   localparam logic [7:0] IDX_SYS_OFS = 8'h54;
   localparam logic [7:0] IDX_CPU_OFS = 8'h55;
   localparam logic [7:0] IDX_AUX_OFS = 8'h56;
   localparam logic [7:0] IDX_LIVE1 = 8'h59;
   localparam logic [7:0] IDX_LIVE2 = 8'h5a;
   localparam logic [7:0] IDX_LIVE3 = 8'h5b;
   localparam logic [7:0] IDX_IRQ_CLR = 8'h5e;
   localparam logic [7:0] IDX_VRAM_FIRST = 8'h50;
   localparam logic [7:0] IDX_VRAM_LAST = 8'h57;
   // Value RAM words
   localparam int VRAM_WORDS = 8;
   localparam logic [2:0] VR_SB = 3'h0;
   localparam logic [2:0] VR_BAT = 3'h1;
   localparam logic [2:0] VR_SB_HI = 3'h4;
   localparam logic [2:0] VR_SB_LO = 3'h5;
   localparam logic [2:0] VR_BAT_HI = 3'h6;
   localparam logic [2:0] VR_BAT_LO = 3'h7;
   // Reset values
   localparam logic [7:0] AUX_LIM_HI_RST = 8'h50;
   localparam logic [7:0] AUX_LIM_LO_RST = 8'h00;
   localparam logic [7:0] IRQ_MASK_RST = 8'h00;
   localparam logic [7:0] ALM_CTL_RST = 8'h00;
   localparam logic [7:0] OFS_RST = 8'h00;
   localparam logic [7:0] MON_CTRL_RST = 8'h00;
   localparam logic [7:0] VRAM_RST = 8'h00;
   // Field positions and writable masks
   localparam int IRQ_AUX_WARN_BIT = 2;
   localparam int IRQ_BAT_BIT = 1;
   localparam int IRQ_SB_BIT = 0;
   localparam logic [7:0] IRQ_MASK_VALID = 8'h13;
   localparam logic [7:0] AUX_LIM_LO_VALID = 8'h80;
   localparam int ALM_FORCE_BIT = 5;
   localparam int ALM_BAT_BIT = 1;
   localparam int ALM_SB_BIT = 0;
   localparam logic [7:0] ALM_CTL_VALID = 8'h23;
   localparam int MON_BAT_EN_BIT = 0;
   localparam int CLR_CASE_BIT = 4;

   typedef enum logic [1:0] {ST_IDLE, ST_WAIT1, ST_WAIT2, ST_DONE} hsa_bus_state_t;
endpackage : hsa_pkg

// >>> core/hsa_vram_if.sv
// Interface between the register block and its value RAM
`timescale 1ns/1ps
interface hsa_vram_if;
   logic sw_we;
   logic [2:0] sw_addr;
   logic [7:0] sw_wdata;
   logic sb_we;
   logic bat_we;
   logic [7:0] sb_wdata;
   logic [7:0] bat_wdata;
   logic [2:0] raddr;
   logic [7:0] rdata;
   logic [7:0] sb_now;
   logic [7:0] bat_now;
   logic [7:0] sb_hi;
   logic [7:0] sb_lo;
   logic [7:0] bat_hi;
   logic [7:0] bat_lo;
   modport ctrl (output sw_we, sw_addr, sw_wdata, sb_we, bat_we, sb_wdata, bat_wdata, raddr,
                 input rdata, sb_now, bat_now, sb_hi, sb_lo, bat_hi, bat_lo);
   modport mem (input sw_we, sw_addr, sw_wdata, sb_we, bat_we, sb_wdata, bat_wdata, raddr,
                output rdata, sb_now, bat_now, sb_hi, sb_lo, bat_hi, bat_lo);
endinterface : hsa_vram_if

// >>> core/hsa_vram.sv
// Value RAM holding standby-rail and battery readings and limits
`timescale 1ns/1ps
module hsa_vram
   import hsa_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   hsa_vram_if.mem vif
);
   logic [7:0] mem_reg [VRAM_WORDS];
   logic [7:0] rdata_reg;

   // Hardware readings and software limits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < VRAM_WORDS; i++) begin
            mem_reg[i] <= VRAM_RST;
         end
      end else begin
         if (vif.sw_we) begin
            mem_reg[vif.sw_addr] <= vif.sw_wdata;
         end
         if (vif.sb_we) begin
            mem_reg[VR_SB] <= vif.sb_wdata;
         end
         if (vif.bat_we) begin
            mem_reg[VR_BAT] <= vif.bat_wdata;
         end
      end
   end

   // Registered read port
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_reg <= VRAM_RST;
      end else begin
         rdata_reg <= mem_reg[vif.raddr];
      end
   end

   assign vif.rdata = rdata_reg;
   assign vif.sb_now = mem_reg[VR_SB];
   assign vif.bat_now = mem_reg[VR_BAT];
   assign vif.sb_hi = mem_reg[VR_SB_HI];
   assign vif.sb_lo = mem_reg[VR_SB_LO];
   assign vif.bat_hi = mem_reg[VR_BAT_HI];
   assign vif.bat_lo = mem_reg[VR_BAT_LO];
endmodule : hsa_vram

// >>> core/hsa_regs.sv
// Hardware-monitor alarm and status register bank on AHB-Lite
// Function
// - Aux limit high byte holds limit bits 8..1, resets to 80 C.
// - Aux limit low byte bit 7 is limit bit 0, reset 0.
// - Status bit 2: aux temp over target 180 ms (180 ticks) in cruise.
// - Status bit 1 battery, bit 0 standby rail out of limits.
// - Mask bits 0, 1, 4 keep status off the interrupt.
// - Alarm control bit 5 forces beep on; resets 0.
// - Alarm control bits 1, 0 enable battery, standby rail beep.
// - Reported temperature is monitored value plus its offset.
// - Live I bits 7, 6: processor, system fan over limit.
// - Live I bits 5, 4: processor, system temperature hysteresis.
// - Live I bits 3..0: analog supply, inputs b, a, core.
// - Live II bits 7, 6: processor, system cruise warnings.
// - Live II bit 5 aux hysteresis; bit 4 latched case open.
// - Live II bit 3 processor fan, bit 0 input c.
// - Live III resets 0: aux warning, battery, standby rail.
// - Value RAM: readings and limits; battery valid when monitoring.
// - Monitor control bit 0 enables battery reading updates.
`timescale 1ns/1ps
module hsa_regs
   import hsa_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES,
   parameter int WARN_TKS = WARN_TICKS
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [7:0] system_temp_input,
   input wire logic [7:0] processor_temp_input,
   input wire logic [7:0] aux_temp_input,
   input wire logic [7:0] standby_rail_input,
   input wire logic [7:0] battery_input,
   input wire logic processor_fan_tach_over,
   input wire logic system_fan_tach_over,
   input wire logic analog_supply_out,
   input wire logic voltage_input_b_out,
   input wire logic voltage_input_a_out,
   input wire logic processor_core_voltage_out,
   input wire logic voltage_input_c_out,
   input wire logic processor_cruise_hot,
   input wire logic system_cruise_hot,
   input wire logic aux_cruise_hot,
   input wire logic case_open,
   input wire logic monitor_cycle,
   input wire logic [8:0] processor_temp_limit,
   input wire logic [8:0] processor_temp_hyst,
   input wire logic [8:0] system_temp_limit,
   input wire logic [8:0] system_temp_hyst,
   input wire logic [8:0] aux_temp_hyst,
   output logic system_mgmt_interrupt,
   output logic beep,
   output logic [7:0] system_temp_report,
   output logic [7:0] processor_temp_report,
   output logic [7:0] aux_temp_report
);
   localparam int SYNC_W = 52;

   function automatic logic hyst_next(logic cur, logic [8:0] t, logic [8:0] lim,
                                      logic [8:0] hys);
      logic r;
      r = cur;
      if (t > lim) begin
         r = 1'b1;
      end else if (t < hys) begin
         r = 1'b0;
      end
      return r;
   endfunction : hyst_next

   function automatic logic out_of(logic [7:0] v, logic [7:0] hi, logic [7:0] lo);
      return (v > hi) || (v < lo);
   endfunction : out_of

   hsa_vram_if vif ();

   hsa_vram u_vram (
      .hclk(hclk),
      .hresetn(hresetn),
      .vif(vif.mem)
   );

   // Pin synchroniser
   logic [SYNC_W-1:0] sync1_reg;
   logic [SYNC_W-1:0] sync2_reg;
   wire [SYNC_W-1:0] pins_raw = {system_temp_input, processor_temp_input, aux_temp_input,
      standby_rail_input, battery_input, processor_fan_tach_over, system_fan_tach_over,
      analog_supply_out, voltage_input_b_out, voltage_input_a_out,
      processor_core_voltage_out, voltage_input_c_out, processor_cruise_hot,
      system_cruise_hot, aux_cruise_hot, case_open, monitor_cycle};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= pins_raw;
         sync2_reg <= sync1_reg;
      end
   end

   wire [7:0] s_sys_t = sync2_reg[51:44];
   wire [7:0] s_cpu_t = sync2_reg[43:36];
   wire [7:0] s_aux_t = sync2_reg[35:28];
   wire [7:0] s_sb = sync2_reg[27:20];
   wire [7:0] s_bat = sync2_reg[19:12];
   wire [1:0] s_fan = sync2_reg[11:10];
   wire [3:0] s_volt1 = sync2_reg[9:6];
   wire s_vin_c = sync2_reg[5];
   wire [2:0] s_cruise = sync2_reg[4:2];
   wire s_case = sync2_reg[1];
   wire s_mon = sync2_reg[0];

   // Bus state
   hsa_bus_state_t state_reg, state_next;
   logic [13:0] a_reg;
   logic a_ok_reg, wr_reg, hreadyout_reg, hresp_reg;
   logic [31:0] hrdata_reg;

   // Block state
   logic [7:0] mon_ctrl_reg, aux_lim_hi_reg, aux_lim_lo_reg, irq_mask_reg, alm_ctl_reg;
   logic [7:0] sys_ofs_reg, cpu_ofs_reg, aux_ofs_reg, sys_rep_reg, cpu_rep_reg, aux_rep_reg;
   logic [2:0] irq_stat_reg, irq_stat_next, hot_reg;
   logic case_reg, case_d_reg, mon_d_reg, sb_out_reg, bat_out_reg, smi_reg, beep_reg;
   logic [31:0] tick_cnt_reg;
   logic [31:0] warn_cnt_reg [3];
   logic [7:0] rd_byte;

   // Address decode
   wire accept = hsel && hready && (htrans == HTRANS_NONSEQ);
   wire [3:0] bank = a_reg[13:10];
   wire [7:0] idx = a_reg[9:2];
   wire in_ctrl = a_ok_reg && (bank == BANK_CTRL);
   wire in_aux = a_ok_reg && (bank == BANK_AUX);
   wire in_alm = a_ok_reg && (bank == BANK_ALM);
   wire sel_mon = in_ctrl && (idx == IDX_MON_CTRL);
   wire sel_lim_hi = in_aux && (idx == IDX_AUX_LIM_HI);
   wire sel_lim_lo = in_aux && (idx == IDX_AUX_LIM_LO);
   wire sel_stat = in_alm && (idx == IDX_IRQ_STAT);
   wire sel_mask = in_alm && (idx == IDX_IRQ_MASK);
   wire sel_alm = in_alm && (idx == IDX_ALM_CTL);
   wire sel_sys_ofs = in_alm && (idx == IDX_SYS_OFS);
   wire sel_cpu_ofs = in_alm && (idx == IDX_CPU_OFS);
   wire sel_aux_ofs = in_alm && (idx == IDX_AUX_OFS);
   wire sel_live1 = in_alm && (idx == IDX_LIVE1);
   wire sel_live2 = in_alm && (idx == IDX_LIVE2);
   wire sel_live3 = in_alm && (idx == IDX_LIVE3);
   wire sel_clr = in_alm && (idx == IDX_IRQ_CLR);
   wire sel_vram = a_ok_reg && (bank == BANK_VRAM) && (idx >= IDX_VRAM_FIRST) &&
                   (idx <= IDX_VRAM_LAST);
   wire wr_stb = (state_reg == ST_WAIT1) && wr_reg;
   wire [7:0] wd = hwdata[7:0];
   wire clr_stb = wr_stb && sel_clr;

   // Derived conditions
   wire bat_en = mon_ctrl_reg[MON_BAT_EN_BIT];
   wire mon_pulse = s_mon && !mon_d_reg;
   wire case_rise = s_case && !case_d_reg;
   wire tick = (tick_cnt_reg == 32'(TICK_CYC - 1));
   wire [2:0] warn;
   wire [8:0] aux_lim = {aux_lim_hi_reg, aux_lim_lo_reg[7]};
   wire [2:0] irq_evt;
   wire [7:0] live1 = {s_fan, hot_reg[1], hot_reg[0], s_volt1};
   wire [7:0] live2 = {warn[2], warn[1], hot_reg[2], case_reg, s_fan[1], 2'h0,
                       s_vin_c};
   wire [7:0] live3 = {5'h00, warn[0], bat_out_reg, sb_out_reg};

   for (genvar g = 0; g < 3; g++) begin : g_warn
      assign warn[g] = (warn_cnt_reg[g] == 32'(WARN_TKS));
   end

   assign irq_evt[IRQ_AUX_WARN_BIT] = warn[0];
   assign irq_evt[IRQ_BAT_BIT] = bat_out_reg;
   assign irq_evt[IRQ_SB_BIT] = sb_out_reg;
   assign irq_stat_next = (irq_stat_reg & ~(clr_stb ? wd[2:0] : 3'h0)) | irq_evt;

   // Value RAM connections
   assign vif.sw_we = wr_stb && sel_vram && idx[2];
   assign vif.sw_addr = idx[2:0];
   assign vif.sw_wdata = wd;
   assign vif.sb_we = mon_pulse;
   assign vif.bat_we = mon_pulse && bat_en;
   assign vif.sb_wdata = s_sb;
   assign vif.bat_wdata = s_bat;
   assign vif.raddr = idx[2:0];

   // Read data select
   always_comb begin
      rd_byte = 8'h00;
      if (sel_mon) rd_byte = mon_ctrl_reg;
      else if (sel_lim_hi) rd_byte = aux_lim_hi_reg;
      else if (sel_lim_lo) rd_byte = aux_lim_lo_reg;
      else if (sel_stat) rd_byte = {5'h00, irq_stat_reg};
      else if (sel_mask) rd_byte = irq_mask_reg;
      else if (sel_alm) rd_byte = alm_ctl_reg;
      else if (sel_sys_ofs) rd_byte = sys_ofs_reg;
      else if (sel_cpu_ofs) rd_byte = cpu_ofs_reg;
      else if (sel_aux_ofs) rd_byte = aux_ofs_reg;
      else if (sel_live1) rd_byte = live1;
      else if (sel_live2) rd_byte = live2;
      else if (sel_live3) rd_byte = live3;
      else if (sel_vram) rd_byte = vif.rdata;
   end

   // Bus sequencing
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: state_next = accept ? ST_WAIT1 : ST_IDLE;
         ST_WAIT1: state_next = ST_WAIT2;
         ST_WAIT2: state_next = ST_DONE;
         ST_DONE: state_next = accept ? ST_WAIT1 : ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= ST_IDLE;
         hreadyout_reg <= 1'b1;
         hresp_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         hreadyout_reg <= (state_next == ST_IDLE) || (state_next == ST_DONE);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_reg <= '0;
         a_ok_reg <= 1'b0;
         wr_reg <= 1'b0;
         hrdata_reg <= '0;
      end else begin
         if (accept && (state_reg != ST_WAIT1) && (state_reg != ST_WAIT2)) begin
            a_reg <= haddr[13:0];
            a_ok_reg <= (haddr[31:14] == 18'h00000) && (haddr[1:0] == 2'h0);
            wr_reg <= hwrite;
         end
         if ((state_reg == ST_WAIT2) && !wr_reg) begin
            hrdata_reg <= {24'h0, rd_byte};
         end
      end
   end

   // Software-written registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mon_ctrl_reg <= MON_CTRL_RST;
         aux_lim_hi_reg <= AUX_LIM_HI_RST;
         aux_lim_lo_reg <= AUX_LIM_LO_RST;
         irq_mask_reg <= IRQ_MASK_RST;
         alm_ctl_reg <= ALM_CTL_RST;
      end else if (wr_stb) begin
         if (sel_mon) mon_ctrl_reg <= wd;
         if (sel_lim_hi) aux_lim_hi_reg <= wd;
         if (sel_lim_lo) aux_lim_lo_reg <= wd & AUX_LIM_LO_VALID;
         if (sel_mask) irq_mask_reg <= wd & IRQ_MASK_VALID;
         if (sel_alm) alm_ctl_reg <= wd & ALM_CTL_VALID;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sys_ofs_reg <= OFS_RST;
         cpu_ofs_reg <= OFS_RST;
         aux_ofs_reg <= OFS_RST;
      end else if (wr_stb) begin
         if (sel_sys_ofs) sys_ofs_reg <= wd;
         if (sel_cpu_ofs) cpu_ofs_reg <= wd;
         if (sel_aux_ofs) aux_ofs_reg <= wd;
      end
   end

   // Reported temperatures and hysteresis status
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sys_rep_reg <= 8'h00;
         cpu_rep_reg <= 8'h00;
         aux_rep_reg <= 8'h00;
         hot_reg <= 3'h0;
      end else begin
         sys_rep_reg <= s_sys_t + sys_ofs_reg;
         cpu_rep_reg <= s_cpu_t + cpu_ofs_reg;
         aux_rep_reg <= s_aux_t + aux_ofs_reg;
         hot_reg[0] <= hyst_next(hot_reg[0], {sys_rep_reg, 1'b0}, system_temp_limit,
                                 system_temp_hyst);
         hot_reg[1] <= hyst_next(hot_reg[1], {cpu_rep_reg, 1'b0}, processor_temp_limit,
                                 processor_temp_hyst);
         hot_reg[2] <= hyst_next(hot_reg[2], {aux_rep_reg, 1'b0}, aux_lim,
                                 aux_temp_hyst);
      end
   end

   // Millisecond tick and cruise warning timers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_cnt_reg <= '0;
         for (int i = 0; i < 3; i++) warn_cnt_reg[i] <= '0;
      end else begin
         tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
         for (int i = 0; i < 3; i++) begin
            if (!s_cruise[i]) begin
               warn_cnt_reg[i] <= '0;
            end else if (tick && !warn[i]) begin
               warn_cnt_reg[i] <= warn_cnt_reg[i] + 32'h1;
            end
         end
      end
   end

   // Limit checks, case latch, edges
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sb_out_reg <= 1'b0;
         bat_out_reg <= 1'b0;
         case_reg <= 1'b0;
         case_d_reg <= 1'b0;
         mon_d_reg <= 1'b0;
      end else begin
         sb_out_reg <= out_of(vif.sb_now, vif.sb_hi, vif.sb_lo);
         bat_out_reg <= bat_en && out_of(vif.bat_now, vif.bat_hi, vif.bat_lo);
         case_reg <= case_rise || (case_reg && !(clr_stb && wd[CLR_CASE_BIT]));
         case_d_reg <= s_case;
         mon_d_reg <= s_mon;
      end
   end

   // Sticky status, interrupt and beep
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat_reg <= 3'h0;
         smi_reg <= 1'b0;
         beep_reg <= 1'b0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         smi_reg <= |(irq_stat_next[1:0] & ~irq_mask_reg[1:0]) ||
                    (irq_stat_next[2] && !irq_mask_reg[4]);
         beep_reg <= alm_ctl_reg[ALM_FORCE_BIT] ||
                     (alm_ctl_reg[ALM_SB_BIT] && sb_out_reg) ||
                     (alm_ctl_reg[ALM_BAT_BIT] && bat_out_reg);
      end
   end

   assign hreadyout = hreadyout_reg;
   assign hresp = hresp_reg;
   assign hrdata = hrdata_reg;
   assign system_mgmt_interrupt = smi_reg;
   assign beep = beep_reg;
   assign system_temp_report = sys_rep_reg;
   assign processor_temp_report = cpu_rep_reg;
   assign aux_temp_report = aux_rep_reg;
endmodule : hsa_regs

// >>> verification/hsa_regs_props.sv
// Port checker for the alarm register bank
`timescale 1ns/1ps
module hsa_regs_props
   import hsa_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic [7:0] system_temp_input,
   input wire logic [7:0] aux_temp_input,
   input wire logic processor_fan_tach_over,
   input wire logic system_mgmt_interrupt,
   input wire logic beep,
   input wire logic [7:0] system_temp_report,
   input wire logic [7:0] aux_temp_report
);
   logic [11:0] ad_reg;
   logic we_reg;
   logic wp_reg;
   logic [7:0] alm_reg;
   logic [7:0] msk_reg;
   logic [7:0] sof_reg;
   logic [7:0] aof_reg;
   wire taken = hsel && hready && htrans == HTRANS_NONSEQ;
   wire [7:0] wd = hwdata[7:0];
   wire rd_l1 = !we_reg && ad_reg == {BANK_ALM, IDX_LIVE1};
   // Shadow copies of written control registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {ad_reg, we_reg, wp_reg, alm_reg, msk_reg, sof_reg, aof_reg} <= '0;
      end else begin
         wp_reg <= taken && hwrite;
         if (taken) {ad_reg, we_reg} <= {haddr[13:2], hwrite};
         if (wp_reg && ad_reg == {BANK_ALM, IDX_ALM_CTL}) alm_reg <= wd & ALM_CTL_VALID;
         if (wp_reg && ad_reg == {BANK_ALM, IDX_IRQ_MASK}) msk_reg <= wd & IRQ_MASK_VALID;
         if (wp_reg && ad_reg == {BANK_ALM, IDX_SYS_OFS}) sof_reg <= wd;
         if (wp_reg && ad_reg == {BANK_ALM, IDX_AUX_OFS}) aof_reg <= wd;
      end
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   AST_WAIT_STATES: assert property (taken |=> !hreadyout ##1 !hreadyout ##1 hreadyout)
      else $error("transfer wait states wrong");
   AST_RDATA_HOLD: assert property (!$rose(hreadyout) |-> $stable(hrdata))
      else $error("read data moved outside a read");
   AST_FORCE_BEEP: assert property ($past(alm_reg[ALM_FORCE_BIT]) |-> beep)
      else $error("forced beep missing");
   AST_BEEP_QUIET: assert property ($past(alm_reg) == 8'h00 &&
      $past(alm_reg, 2) == 8'h00 |-> !beep)
      else $error("beep without cause");
   AST_MASK_ALL: assert property ($past(msk_reg) == IRQ_MASK_VALID &&
      $past(msk_reg, 2) == IRQ_MASK_VALID |-> !system_mgmt_interrupt)
      else $error("masked interrupt raised");
   AST_SYS_OFFSET: assert property (($stable(system_temp_input) && $stable(sof_reg)) [*4]
      |-> system_temp_report == system_temp_input + sof_reg)
      else $error("system report not input plus offset");
   AST_AUX_OFFSET: assert property (($stable(aux_temp_input) && $stable(aof_reg)) [*4]
      |-> aux_temp_report == aux_temp_input + aof_reg)
      else $error("aux report not input plus offset");
   AST_FAN_READ: assert property ($rose(hreadyout) && rd_l1 &&
      $past(processor_fan_tach_over, 6) == processor_fan_tach_over
      |-> hrdata[7] == processor_fan_tach_over)
      else $error("fan status bit wrong");
   cover property ($rose(beep));
   cover property ($rose(system_mgmt_interrupt));
   cover property ($rose(hreadyout) && rd_l1);
endmodule : hsa_regs_props

bind hsa_regs hsa_regs_props hsa_regs_props_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
   .hwdata, .hready, .hreadyout, .hrdata, .system_temp_input, .aux_temp_input,
   .processor_fan_tach_over, .system_mgmt_interrupt, .beep, .system_temp_report,
   .aux_temp_report);

// >>> verification/hsa_fe.sv
// Sensor front end model driving the monitor inputs
`timescale 1ns/1ps
module hsa_fe (
   input wire logic hclk,
   output logic [7:0] t_sys,
   output logic [7:0] t_cpu,
   output logic [7:0] t_aux,
   output logic [7:0] sb,
   output logic [7:0] bat,
   output logic [10:0] flg,
   output logic mc
);
   logic [2:0] cnt;
   initial begin
      {t_sys, t_cpu, t_aux, sb, bat, flg, mc, cnt} = '0;
   end
   // Monitor cycle ends every 8 clocks
   always @(posedge hclk) begin
      cnt <= cnt + 3'h1;
      mc <= cnt == 3'h7;
   end
endmodule : hsa_fe

// >>> verification/hsa_regs_tb_top.sv
// Testbench for the alarm register bank
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
   $display("Error at %0t: got %h expected %h", $time, a, e); end end
module hsa_regs_tb_top
   import hsa_pkg::*;
();
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, beep, mc;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata;
   logic [7:0] ts, tp, ta, sb, bt, rep_s, rep_p, rep_a;
   logic [10:0] flg;
   logic [8:0] lim, hys;
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   hsa_fe hsa_fe_i (.hclk(hclk), .t_sys(ts), .t_cpu(tp), .t_aux(ta), .sb(sb), .bat(bt),
      .flg(flg), .mc(mc));
   hsa_regs #(.TICK_CYC(4), .WARN_TKS(3)) hsa_regs_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
      .system_temp_input(ts), .processor_temp_input(tp), .aux_temp_input(ta),
      .standby_rail_input(sb), .battery_input(bt), .processor_fan_tach_over(flg[0]),
      .system_fan_tach_over(flg[1]), .analog_supply_out(flg[2]), .voltage_input_b_out(flg[3]),
      .voltage_input_a_out(flg[4]), .processor_core_voltage_out(flg[5]),
      .voltage_input_c_out(flg[6]), .processor_cruise_hot(flg[7]), .system_cruise_hot(flg[8]),
      .aux_cruise_hot(flg[9]), .case_open(flg[10]), .monitor_cycle(mc),
      .processor_temp_limit(lim), .processor_temp_hyst(hys), .system_temp_limit(lim),
      .system_temp_hyst(hys), .aux_temp_hyst(hys), .system_mgmt_interrupt(irq),
      .beep, .system_temp_report(rep_s), .processor_temp_report(rep_p),
      .aux_temp_report(rep_a));
   task automatic stop_test();
      if (fail_count == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test
   task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] d,
                      output logic [7:0] q);
      haddr <= {18'h0, a, 2'h0};
      hwrite <= w;
      htrans <= HTRANS_NONSEQ;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata[7:0];
   endtask : bus
   task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [3:0] b = BANK_ALM);
      logic [7:0] q;
      bus({b, i}, 1'b1, d, q);
   endtask : wr
   task automatic rc(input logic [7:0] i, input logic [7:0] e, input logic [3:0] b = BANK_ALM);
      logic [7:0] q;
      bus({b, i}, 1'b0, 8'h00, q);
      `CHK(q, e)
      `CHK(hresp, 1'b0)
   endtask : rc
   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask : tick
   task automatic t_regs();
      rc(IDX_AUX_LIM_HI, AUX_LIM_HI_RST, BANK_AUX);
      rc(IDX_AUX_LIM_LO, 8'h00, BANK_AUX);
      rc(IDX_ALM_CTL, 8'h00);
      rc(IDX_SYS_OFS, 8'h00);
      rc(IDX_LIVE3, 8'h00);
      rc(8'h52, 8'h00);
      wr(IDX_AUX_LIM_HI, 8'h9a, BANK_AUX);
      rc(IDX_AUX_LIM_HI, 8'h9a, BANK_AUX);
      wr(IDX_AUX_LIM_LO, 8'hff, BANK_AUX);
      rc(IDX_AUX_LIM_LO, 8'h80, BANK_AUX);
      wr(IDX_IRQ_MASK, 8'hff);
      rc(IDX_IRQ_MASK, 8'h13);
      wr(IDX_ALM_CTL, 8'hff);
      rc(IDX_ALM_CTL, 8'h23);
      `CHK(beep, 1'b1)
      wr(IDX_ALM_CTL, 8'h00);
      tick(2);
      `CHK(beep, 1'b0)
      wr(IDX_LIVE3, 8'hff);
      rc(IDX_LIVE3, 8'h00);
      wr(IDX_IRQ_MASK, 8'h00);
   endtask : t_regs
   task automatic t_offset();
      {hsa_fe_i.t_sys, hsa_fe_i.t_cpu, hsa_fe_i.t_aux} <= 24'h203010;
      wr(IDX_SYS_OFS, 8'h05);
      wr(IDX_CPU_OFS, 8'h02);
      wr(IDX_AUX_OFS, 8'hff);
      tick(6);
      `CHK({rep_s, rep_p, rep_a}, 24'h25320f)
   endtask : t_offset
   task automatic t_live();
      hsa_fe_i.flg <= 11'h055;
      tick(8);
      rc(IDX_LIVE1, 8'h8a);
      rc(IDX_LIVE2, 8'h09);
      hsa_fe_i.flg <= 11'h02a;
      tick(8);
      rc(IDX_LIVE1, 8'h45);
      rc(IDX_LIVE2, 8'h00);
      hsa_fe_i.flg <= 11'h400;
      tick(6);
      hsa_fe_i.flg <= 11'h000;
      rc(IDX_LIVE2, 8'h10);
      wr(IDX_IRQ_CLR, 8'h10);
      rc(IDX_LIVE2, 8'h00);
      hsa_fe_i.t_cpu <= 8'h90;
      tick(8);
      rc(IDX_LIVE1, 8'h20);
      hsa_fe_i.t_cpu <= 8'h7a;
      tick(8);
      rc(IDX_LIVE1, 8'h20);
      hsa_fe_i.t_cpu <= 8'h60;
      tick(8);
      rc(IDX_LIVE1, 8'h00);
   endtask : t_live
   task automatic t_rail();
      wr(8'h54, 8'h80, BANK_VRAM);
      wr(8'h55, 8'h10, BANK_VRAM);
      hsa_fe_i.sb <= 8'h90;
      tick(20);
      rc(8'h50, 8'h90, BANK_VRAM);
      rc(IDX_IRQ_STAT, 8'h01);
      rc(IDX_LIVE3, 8'h01);
      `CHK({irq, beep}, 2'b10)
      wr(IDX_ALM_CTL, 8'h01);
      wr(IDX_IRQ_MASK, 8'h01);
      tick(2);
      `CHK({irq, beep}, 2'b01)
      wr(8'h50, 8'h00, BANK_VRAM);
      rc(8'h50, 8'h90, BANK_VRAM);
      hsa_fe_i.sb <= 8'h40;
      tick(20);
      rc(IDX_IRQ_STAT, 8'h01);
      wr(IDX_IRQ_MASK, 8'h00);
      wr(IDX_IRQ_CLR, 8'h07);
      rc(IDX_IRQ_STAT, 8'h00);
      `CHK({irq, beep}, 2'b00)
   endtask : t_rail
   task automatic t_battery();
      wr(8'h56, 8'h80, BANK_VRAM);
      wr(8'h57, 8'h10, BANK_VRAM);
      hsa_fe_i.bat <= 8'h50;
      tick(20);
      rc(8'h51, 8'h00, BANK_VRAM);
      rc(IDX_LIVE3, 8'h00);
      wr(IDX_MON_CTRL, 8'h01, BANK_CTRL);
      tick(20);
      rc(8'h51, 8'h50, BANK_VRAM);
      hsa_fe_i.bat <= 8'h05;
      tick(20);
      rc(IDX_LIVE3, 8'h02);
      rc(IDX_IRQ_STAT, 8'h02);
      hsa_fe_i.bat <= 8'h50;
      tick(20);
      wr(IDX_IRQ_CLR, 8'h07);
      rc(IDX_IRQ_STAT, 8'h00);
   endtask : t_battery
   task automatic t_cruise();
      hsa_fe_i.flg <= 11'h280;
      rc(IDX_LIVE3, 8'h00);
      tick(20);
      rc(IDX_LIVE2, 8'h80);
      rc(IDX_LIVE3, 8'h04);
      rc(IDX_IRQ_STAT, 8'h04);
      hsa_fe_i.flg <= 11'h000;
      tick(4);
      rc(IDX_LIVE2, 8'h00);
   endtask : t_cruise
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc++;
      if (cyc > 20000) begin
         fail_count++;
         stop_test();
      end
   end
   initial begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      lim = 9'h100;
      hys = 9'h0f0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      hsel <= 1'b1;
      @(posedge hclk);
      t_regs();
      t_offset();
      t_live();
      t_rail();
      t_battery();
      t_cruise();
      stop_test();
   end
endmodule : hsa_regs_tb_top
